// file: hdl/dmx_exec.sv
// decode and execute of the four data-move instructions
// Overview of operation
// - file move is two words: 1100 plus source, then 1111 plus destination
// - file move source and destination reach 000h..FFFh without bank select
// - file move allows accumulator either end, copies byte, no flags touched
// - file move first cycle: decode, read source in Q2, no Q4 write
// - file move second cycle: no read at all, write destination in Q4
// - bank load 0000 0001 kkkk kkkk writes bank select, one cycle, no flags
// - after bank load, upper four bank select bits read zero
// - accumulator load 0000 1110 kkkk kkkk sets accumulator in one cycle
// - accumulator store 0110 111a ffff ffff writes accumulator to file
// - store file address picks a byte within a 256-byte bank
// - access bit clear selects access bank, set uses bank select register
// - extended mode, access bit clear, address up to 5Fh: indexed offset
module dmx_exec
   import dmx_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        rst_b,
   input  wire logic [15:0] instr_word,
   input  wire logic        instr_vld,
   input  wire logic        ext_en,
   input  wire logic [11:0] idx_base,
   input  wire logic [7:0]  dm_rdata,
   output logic      [11:0] dm_addr,
   output logic             dm_rd,
   output logic             dm_wr,
   output logic      [7:0]  dm_wdata,
   output logic      [7:0]  wreg,
   output logic      [7:0]  bank_sel
);
   typedef struct packed {
      dmx_kind_t   kind;
      logic [15:0] word;
      logic        acc_end;
      logic [7:0]  data;
      logic [7:0]  wreg;
      logic [7:0]  bank_sel;
      logic [11:0] addr;
      logic        rd;
      logic        wr;
      logic [7:0]  wdata;
   } dmx_state_t;

   dmx_state_t s_q;
   dmx_state_t s_d;
   logic [1:0] phase;

   dmx_qphase u_qphase (
      .clk_sys (clk_sys),
      .rst_b   (rst_b),
      .phase   (phase)
   );

   function automatic dmx_kind_t fn_decode(input logic [15:0] w, input logic vld,
                                           input logic second);
      dmx_kind_t k;
      k = K_NONE;
      if (vld) begin
         // a lone 1111 word is a no-op; only after a first word is it a destination
         if (second) begin
            k = (w[15:12] == OP_MOVE_DST) ? K_MOVE2 : K_NONE;
         end else if (w[15:12] == OP_MOVE_SRC) begin
            k = K_MOVE1;
         end else if (w[15:8] == OP_BANK_LIT) begin
            k = K_BANK;
         end else if (w[15:8] == OP_ACC_LIT) begin
            k = K_ACC;
         end else if (w[15:9] == OP_ACC_STORE) begin
            k = K_STORE;
         end
      end
      return k;
   endfunction : fn_decode

   function automatic logic [11:0] fn_bank_addr(input logic [7:0] f, input logic a,
                                                input logic [7:0] bank, input logic ext,
                                                input logic [11:0] base);
      logic [11:0] r;
      r = {bank[3:0], f};
      if (!a) begin
         if (ext && f <= IDX_LIMIT) begin
            r = 12'(base + {4'h0, f});
         end else if (f < ACC_SPLIT) begin
            r = {4'h0, f};
         end else begin
            r = {ACC_HI_BANK, f};
         end
      end
      return r;
   endfunction : fn_bank_addr

   always_comb begin
      s_d = s_q;
      case (phase)
         PH_Q1: begin
            s_d.kind    = fn_decode(instr_word, instr_vld, s_q.kind == K_MOVE1);
            s_d.word    = instr_word;
            s_d.addr    = instr_word[11:0];
            s_d.acc_end = (instr_word[11:0] == ACC_MAP_ADDR);
            if (s_d.kind == K_STORE) begin
               s_d.addr = fn_bank_addr(instr_word[7:0], instr_word[8], s_q.bank_sel,
                                       ext_en, idx_base);
            end
            // accumulator as source is taken internally, no memory read
            s_d.rd = (s_d.kind == K_MOVE1) && !s_d.acc_end;
            s_d.wr = 1'b0;
         end
         PH_Q2: begin
            s_d.rd = 1'b0;
            if (s_q.kind == K_MOVE1) begin
               s_d.data = s_q.acc_end ? s_q.wreg : dm_rdata;
            end
         end
         PH_Q3: begin
            // second move cycle never reads; write lands in Q4
            if (s_q.kind == K_MOVE2 && !s_q.acc_end) begin
               s_d.wr    = 1'b1;
               s_d.wdata = s_q.data;
            end else if (s_q.kind == K_STORE) begin
               s_d.wr    = 1'b1;
               s_d.wdata = s_q.wreg;
            end
         end
         PH_Q4: begin
            s_d.wr = 1'b0;
            case (s_q.kind)
               K_BANK: begin
                  s_d.bank_sel = {BANK_PAD, s_q.word[3:0]};
               end
               K_ACC: begin
                  s_d.wreg = s_q.word[7:0];
               end
               K_MOVE2: begin
                  if (s_q.acc_end) begin
                     s_d.wreg = s_q.data;
                  end
               end
               default: begin
               end
            endcase
         end
         default: begin
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         s_q.kind    <= K_NONE;
         s_q.word    <= 16'h0000;
         s_q.acc_end <= 1'b0;
         s_q.data    <= 8'h00;
         s_q.wreg    <= WREG_RST;
         s_q.bank_sel <= BANK_RST;
         s_q.addr    <= 12'h000;
         s_q.rd      <= 1'b0;
         s_q.wr      <= 1'b0;
         s_q.wdata   <= 8'h00;
      end else begin
         s_q <= s_d;
      end
   end

   assign dm_addr  = s_q.addr;
   assign dm_rd    = s_q.rd;
   assign dm_wr    = s_q.wr;
   assign dm_wdata = s_q.wdata;
   assign wreg     = s_q.wreg;
   assign bank_sel = s_q.bank_sel;

   // checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);

   property p_move_pair;
      s_q.kind == K_MOVE2 |-> $past(s_q.kind, 4) == K_MOVE1;
   endproperty
   a_move_pair: assert property (p_move_pair)
      else $error("destination word without source word");

   property p_move_dst_addr;
      dm_wr && s_q.kind == K_MOVE2 |-> dm_addr == s_q.word[11:0];
   endproperty
   a_move_dst_addr: assert property (p_move_dst_addr)
      else $error("move destination address wrong");

   property p_move_data;
      (dm_rd && s_q.kind == K_MOVE1) ##6 (dm_wr && s_q.kind == K_MOVE2)
         |-> dm_wdata == $past(dm_rdata, 6);
   endproperty
   a_move_data: assert property (p_move_data)
      else $error("moved byte differs from source");

   property p_rd_q2;
      dm_rd |-> phase == PH_Q2 && s_q.kind == K_MOVE1 ##2 !dm_wr;
   endproperty
   a_rd_q2: assert property (p_rd_q2)
      else $error("read outside first move Q2 or followed by write");

   property p_no_rd_second;
      s_q.kind == K_MOVE2 |-> !dm_rd;
   endproperty
   a_no_rd_second: assert property (p_no_rd_second)
      else $error("read in second move cycle");

   property p_wr_q4;
      dm_wr |-> phase == PH_Q4 && $past(phase) == PH_Q3;
   endproperty
   a_wr_q4: assert property (p_wr_q4)
      else $error("write outside Q4");

   property p_bank_load;
      s_q.kind == K_BANK && phase == PH_Q4 |=> bank_sel == {4'h0, $past(s_q.word[3:0])};
   endproperty
   a_bank_load: assert property (p_bank_load)
      else $error("bank load value wrong");

   property p_bank_hi_zero;
      bank_sel[7:4] == 4'h0;
   endproperty
   a_bank_hi_zero: assert property (p_bank_hi_zero)
      else $error("bank select upper bits set");

   property p_acc_load;
      s_q.kind == K_ACC && phase == PH_Q4 |=> wreg == $past(s_q.word[7:0]);
   endproperty
   a_acc_load: assert property (p_acc_load)
      else $error("accumulator load value wrong");

   property p_store_data;
      dm_wr && s_q.kind == K_STORE |-> dm_wdata == wreg;
   endproperty
   a_store_data: assert property (p_store_data)
      else $error("store data is not accumulator");

   property p_store_bank;
      dm_wr && s_q.kind == K_STORE && s_q.word[8]
         |-> dm_addr == {bank_sel[3:0], s_q.word[7:0]};
   endproperty
   a_store_bank: assert property (p_store_bank)
      else $error("banked store address wrong");

   property p_store_index;
      (phase == PH_Q1 && instr_vld && instr_word[15:9] == OP_ACC_STORE
       && s_q.kind != K_MOVE1 && !instr_word[8] && ext_en
       && instr_word[7:0] <= IDX_LIMIT) ##3 dm_wr
         |-> dm_addr == 12'($past(idx_base, 3) + {4'h0, s_q.word[7:0]});
   endproperty
   a_store_index: assert property (p_store_index)
      else $error("indexed store address wrong");

   c_move:  cover property (s_q.kind == K_MOVE2 && dm_wr);
   c_store: cover property (s_q.kind == K_STORE && dm_wr);
   c_bank:  cover property (s_q.kind == K_BANK && phase == PH_Q4);
   c_accw:  cover property (s_q.kind == K_MOVE2 && s_q.acc_end && phase == PH_Q4);
endmodule : dmx_exec

// file: hdl/dmx_pkg.sv
// constants and types for the data-move execute block
package dmx_pkg;
   localparam logic [1:0]  PH_Q1        = 2'h0;
   localparam logic [1:0]  PH_Q2        = 2'h1;
   localparam logic [1:0]  PH_Q3        = 2'h2;
   localparam logic [1:0]  PH_Q4        = 2'h3;
   localparam logic [3:0]  OP_MOVE_SRC  = 4'hC;
   localparam logic [3:0]  OP_MOVE_DST  = 4'hF;
   localparam logic [7:0]  OP_BANK_LIT  = 8'h01;
   localparam logic [7:0]  OP_ACC_LIT   = 8'h0E;
   localparam logic [6:0]  OP_ACC_STORE = 7'h37;
   localparam logic [11:0] ACC_MAP_ADDR = 12'hFE0;
   localparam logic [7:0]  ACC_SPLIT    = 8'h80;
   localparam logic [3:0]  ACC_HI_BANK  = 4'hF;
   localparam logic [7:0]  IDX_LIMIT    = 8'h5F;
   localparam logic [7:0]  WREG_RST     = 8'h00;
   localparam logic [7:0]  BANK_RST     = 8'h00;
   localparam logic [3:0]  BANK_PAD     = 4'h0;

   typedef enum logic [2:0] {
      K_NONE,
      K_MOVE1,
      K_MOVE2,
      K_BANK,
      K_ACC,
      K_STORE
   } dmx_kind_t;
endpackage : dmx_pkg

// file: hdl/dmx_qphase.sv
// quarter-phase sequencer, four clocks per instruction cycle
module dmx_qphase
   import dmx_pkg::*;
(
   input  wire logic       clk_sys,
   input  wire logic       rst_b,
   output logic      [1:0] phase
);
   typedef struct packed {
      logic [1:0] ph;
   } dmx_ph_t;

   dmx_ph_t s_q;
   dmx_ph_t s_d;

   always_comb begin
      s_d    = s_q;
      s_d.ph = s_q.ph + 2'h1;
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         s_q.ph <= PH_Q1;
      end else begin
         s_q <= s_d;
      end
   end

   assign phase = s_q.ph;
endmodule : dmx_qphase

// file: test/dmx_mem_model.sv
// data memory model answering the execute block's strobes
module dmx_mem_model
   import dmx_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic [11:0] dm_addr,
   input  wire logic        dm_rd,
   input  wire logic        dm_wr,
   input  wire logic [7:0]  dm_wdata,
   output logic      [7:0]  dm_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem [4096];
   logic [7:0] last_q;
   initial begin
      for (int i = 0; i < 4096; i++) begin
         mem[i] = 8'((i * 37 + 5) & 255);
      end
      last_q = 8'h00;
   end
   // off a read the bus shows the inverse of the last byte, so a late sample is caught
   always_comb begin
      dm_rdata = dm_rd ? mem[dm_addr] : ~last_q;
   end
   always @(posedge clk_sys) begin
      if (dm_rd) begin
         last_q <= mem[dm_addr];
      end
      if (dm_wr) begin
         mem[dm_addr] <= dm_wdata;
      end
   end
endmodule : dmx_mem_model

// file: test/testbench.sv
// self-checking bench for the data-move execute block
module testbench
   import dmx_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_sys = 1'b0;
   logic        rst_b = 1'b0;
   logic [15:0] instr_word = 16'h0000;
   logic        instr_vld = 1'b0;
   logic        ext_en = 1'b0;
   logic [11:0] idx_base = 12'h000;
   logic [7:0]  dm_rdata;
   logic [11:0] dm_addr;
   logic        dm_rd;
   logic        dm_wr;
   logic [7:0]  dm_wdata;
   logic [7:0]  wreg;
   logic [7:0]  bank_sel;
   int          num_errors = 0;
   int          num_checks = 0;
   int          mir [4096];
   int          ew = 0;
   int          eb = 0;
   int          pbyte = 0;
   bit          pend = 1'b0;

   always #25 clk_sys = ~clk_sys;

   dmx_exec dut (.clk_sys(clk_sys), .rst_b(rst_b), .instr_word(instr_word),
      .instr_vld(instr_vld), .ext_en(ext_en), .idx_base(idx_base), .dm_rdata(dm_rdata),
      .dm_addr(dm_addr), .dm_rd(dm_rd), .dm_wr(dm_wr), .dm_wdata(dm_wdata),
      .wreg(wreg), .bank_sel(bank_sel));
   dmx_mem_model mem (.clk_sys(clk_sys), .dm_addr(dm_addr), .dm_rd(dm_rd), .dm_wr(dm_wr),
      .dm_wdata(dm_wdata), .dm_rdata(dm_rdata));

   task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
      num_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic report_and_stop;
      $display("checks=%0d errors=%0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : report_and_stop

   // called at a rising edge; strobes and address are checked in this call, wreg and bank_sel effects at the next call
   task automatic run(input logic [15:0] w, input logic v, input logic x, input logic [11:0] b);
      int f, ad, erd, ewr, ewd, nw, nb;
      f = w[7:0];
      ad = -1;
      erd = 0;
      ewr = 0;
      ewd = 0;
      nw = ew;
      nb = eb;
      instr_word <= w;
      instr_vld <= v;
      ext_en <= x;
      idx_base <= b;
      if (!v) begin
         pend = 0;
      end else if (pend) begin
         pend = 0;
         if (w[15:12] == OP_MOVE_DST) begin
            ad = w[11:0];
            ewr = (ad != ACC_MAP_ADDR);
            ewd = pbyte;
            if (ewr) mir[ad] = pbyte; else nw = pbyte;
         end
      end else if (w[15:12] == OP_MOVE_SRC) begin
         ad = w[11:0];
         erd = (ad != ACC_MAP_ADDR);
         pbyte = erd ? mir[ad] : ew;
         pend = 1;
      end else if (w[15:8] == OP_BANK_LIT) begin
         nb = f & 15;
      end else if (w[15:8] == OP_ACC_LIT) begin
         nw = f;
      end else if (w[15:9] == OP_ACC_STORE) begin
         if (w[8]) ad = (eb & 15) * 256 + f;
         else if (x && f <= 8'h5F) ad = (b + f) & 12'hFFF;
         else ad = (f < 8'h80) ? f : 12'hF00 + f;
         ewr = 1;
         ewd = ew;
         mir[ad] = ew;
      end
      @(posedge clk_sys);
      #1;
      chk(12'(wreg), 12'(ew));
      chk(12'(bank_sel), 12'(eb));
      if (ad >= 0) chk(dm_addr, 12'(ad));
      chk(12'(dm_rd), 12'(erd));
      @(posedge clk_sys);
      #1;
      chk(12'({dm_rd, dm_wr}), 12'h000);
      @(posedge clk_sys);
      #1;
      chk(12'({dm_rd, dm_wr}), 12'(ewr));
      if (ewr) chk(12'(dm_wdata), 12'(ewd));
      @(posedge clk_sys);
      ew = nw;
      eb = nb;
   endtask : run

   initial begin
      #(5000 * 50);
      num_errors++;
      report_and_stop();
   end

   initial begin
      int k;
      void'($urandom(68));
      for (int i = 0; i < 4096; i++) mir[i] = (i * 37 + 5) & 255;
      repeat (5) @(posedge clk_sys);
      rst_b <= 1'b1;
      run(16'h0EA5, 1, 0, 12'h000);
      run(16'h01F7, 1, 0, 12'h000);
      run(16'h6F34, 1, 0, 12'h000);
      run(16'h6E34, 1, 0, 12'h000);
      run(16'h6E9C, 1, 0, 12'h000);
      run(16'h6E5F, 1, 1, 12'h123);
      run(16'h6E60, 1, 1, 12'hFF0);
      run(16'h6E10, 1, 1, 12'hFF8);
      run(16'hC123, 1, 0, 12'h000);
      run(16'hF456, 1, 0, 12'h000);
      run(16'hCFE0, 1, 0, 12'h000);
      run(16'hF200, 1, 0, 12'h000);
      run(16'hC734, 1, 0, 12'h000);
      run(16'hFFE0, 1, 0, 12'h000);
      run(16'hC100, 1, 0, 12'h000);
      run(16'h0E11, 1, 0, 12'h000);
      run(16'hF300, 1, 0, 12'h000);
      run(16'h0E22, 0, 0, 12'h000);
      run(16'h010F, 1, 0, 12'h000);
      run(16'h6FFF, 1, 0, 12'h000);
      // reset lands mid-cycle; the word is withdrawn first so Q1 does not repeat it
      instr_vld <= 1'b0;
      @(posedge clk_sys);
      rst_b <= 1'b0;
      @(posedge clk_sys);
      #1;
      chk(12'(wreg), 12'(WREG_RST));
      chk(12'(bank_sel), 12'(BANK_RST));
      chk(dm_addr, 12'h000);
      chk(12'({dm_rd, dm_wr}), 12'h000);
      chk(12'(dm_wdata), 12'h000);
      @(posedge clk_sys);
      rst_b <= 1'b1;
      ew = WREG_RST;
      eb = BANK_RST;
      pend = 0;
      for (int n = 0; n < 60; n++) begin
         k = $urandom % 4;
         case (k)
            0: run({8'h0E, 8'($urandom)}, 1, 0, 12'h000);
            1: run({8'h01, 8'($urandom)}, 1, 0, 12'h000);
            2: run({7'h37, 9'($urandom)}, 1, 1'($urandom), 12'($urandom));
            default: begin
               run({4'hC, 12'($urandom)}, 1, 0, 12'h000);
               // destinations stay below the accumulator byte at FE0h near the top of the map
               run({4'hF, 12'($urandom % 12'hFE0)}, 1, 0, 12'h000);
            end
         endcase
      end
      run(16'h0000, 0, 0, 12'h000);
      report_and_stop();
   end
endmodule : testbench
